// >>> shared/vout_ramp_consts.svh
// Offsets, field positions, reset values and timing figures of the output voltage control block
`ifndef VOUT_RAMP_CONSTS_SVH
`define VOUT_RAMP_CONSTS_SVH
`define OFS_OP_CTRL     8'h00
`define OFS_PWM_MODE    8'h04
`define OFS_VOUT_CMD    8'h08
`define OFS_SCALE_LOOP  8'h0c
`define OFS_RAMP_STEP   8'h10
`define OFS_TON_MAX     8'h14
`define OFS_BUSY_STAT   8'h18
`define OFS_VOUT_MAX    8'h1c
`define OFS_STATUS      8'h20
`define OFS_EA_REF      8'h24
`define BIT_OP_ON       0
`define BIT_SERVO_EN    6
`define BIT_BUSY_LO     5
`define BIT_BUSY_HI     6
`define MARGIN_NONE     2'h0
`define MARGIN_LOW      2'h1
`define MARGIN_HIGH     2'h2
`define RST_RAMP_STEP   16'h0010
`define RST_VOUT_CMD    16'h0d20
`define RATE_SKIP       16'hffff
`define FB_REF_CODE     16'h0540
`define CEIL_CODE       16'h2f1c
`define BASE_MAX_CODE   16'h3131
`define MAX_PER_SCALE   16'h0540
`define MARGIN_DIV      16'h0014
`define FAULT_DIV       16'h000a
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define CLK_MHZ         250
`define RECAL_TIME_MS   500
`define STEP_TIME_US    100
`endif

// >>> shared/vout_ramp_pkg.sv
// Types shared by the output voltage control block
package vout_ramp_pkg;
  typedef enum logic [2:0] {RAIL_OFF, RAIL_RISE, RAIL_ON, RAIL_FALL} rail_state_t;
  typedef logic [15:0] vcode_t;
endpackage

// >>> src/vout_ramp_ctrl.sv
// Output voltage target, margining, servo and soft start/stop control with AXI4-Lite registers
// Functional notes
// - Resistor-set mode margins sit five percent below and above nominal.
// - Resistor-set fault limits: undervoltage ten percent below, overvoltage ten above.
// - Default warning limits are disabled; no warning is ever raised.
// - Margin requests from the operation register apply preset margin targets.
// - New scale factor triggers 500 ms of rail-off recalculation, busy shown.
// - Output-voltage writes are held off until recalculation finishes.
// - Maximum output is read-only: scale-derived and capped, the cap itself in resistor-set mode, or fixed base value.
// - With scale factor in use, ramp rate applies to the output itself.
// - Servo moves reference one 297.5 uV step per completed conversion.
// - Servo needs enable bit, soft-start done, no undervoltage, no overcurrent.
// - Servo engages after turn-on time limit; limit zero means engage immediately.
// - Run state precedes soft-start; run released after init and input good.
// - Soft-start ramps target digitally from zero to final value.
// - Target updates at most one step per 100 us.
// - Ramp skipped when transition rate holds the fastest setting.
// - Run low or command off starts soft-off ramp to zero.
// - Stage off at ramp end; any rail fault turns stage off at once.
`include "vout_ramp_consts.svh"
module vout_ramp_ctrl #(
  parameter int          RECAL_CYCLES = `RECAL_TIME_MS * `CLK_MHZ * 1000,
  parameter int          TICK_CYCLES  = `STEP_TIME_US * `CLK_MHZ,
  parameter bit          BASE_VARIANT = 1'b0
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  input  wire logic [7:0]            awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [7:0]            araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire logic                  run_pin,
  input  wire logic                  init_done,
  input  wire logic                  vin_above_on,
  input  wire logic                  adc_valid,
  input  wire vout_ramp_pkg::vcode_t adc_code,
  input  wire logic                  oc_fault,
  input  wire logic                  rail_fault,
  output logic                       run_release,
  output logic                       stage_en,
  output vout_ramp_pkg::vcode_t      ea_ref,
  output logic                       uv_fault,
  output logic                       ov_fault,
  output logic                       servo_active
);
  import vout_ramp_pkg::*;

  function automatic vcode_t step_toward(input vcode_t cur, input vcode_t dst, input vcode_t stp);
    vcode_t gap;
    gap = (dst > cur) ? dst - cur : cur - dst;
    if (gap <= stp) step_toward = dst;
    else if (dst > cur) step_toward = cur + stp;
    else step_toward = cur - stp;
  endfunction

  rail_state_t state;
  logic [2:0]  op_ctrl;
  logic [7:0]  pwm_mode_config;
  vcode_t      vout_cmd;
  vcode_t      scale_loop;
  vcode_t      ramp_step;
  vcode_t      ton_max;
  vcode_t      ramp;
  vcode_t      ton_ticks;
  logic [31:0] busy_cnt;
  logic [31:0] tick_cnt;
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic        wstrb_ok;
  logic [3:0]  wr_strb;

  // Scale factor zero keeps the resistor-set mode unless BASE_VARIANT is set: ramp works on the feedback point
  wire         fb_mode   = (scale_loop == 16'h0000) && !BASE_VARIANT;
  wire vcode_t nominal   = fb_mode ? `FB_REF_CODE : vout_cmd;
  wire vcode_t margin_d  = nominal / `MARGIN_DIV;
  wire vcode_t fault_d   = nominal / `FAULT_DIV;
  wire [1:0]   margin    = op_ctrl[2:1];
  wire vcode_t setpoint  = (margin == `MARGIN_LOW)  ? nominal - margin_d :
                           (margin == `MARGIN_HIGH) ? nominal + margin_d : nominal;
  wire vcode_t uv_limit  = nominal - fault_d;
  wire vcode_t ov_limit  = nominal + fault_d;
  wire [31:0]  scale_max = 32'(scale_loop) * 32'(`MAX_PER_SCALE);
  wire vcode_t vout_max  = BASE_VARIANT ? `BASE_MAX_CODE :
                           (fb_mode || scale_max > 32'(`CEIL_CODE)) ? `CEIL_CODE : scale_max[15:0];
  wire         busy      = (busy_cnt != 32'h0);
  wire         tick      = (tick_cnt == 32'(TICK_CYCLES - 1));
  wire         want_on   = run_release && run_pin && op_ctrl[`BIT_OP_ON] && !busy;
  wire         skip_ramp = (ramp_step == `RATE_SKIP);
  wire         fault_now = rail_fault || uv_fault || ov_fault;
  wire         servo_ok  = pwm_mode_config[`BIT_SERVO_EN] && state == RAIL_ON && !uv_fault && !oc_fault;
  wire         ton_done  = (ton_max == 16'h0000) || (ton_ticks >= ton_max);
  wire         next_servo = servo_ok && ton_done;
  wire         vout_rel  = wr_addr == `OFS_VOUT_CMD || wr_addr == `OFS_SCALE_LOOP ||
                           wr_addr == `OFS_RAMP_STEP || wr_addr == `OFS_OP_CTRL;
  wire         do_wr     = aw_hold && w_hold && !bvalid && !(busy && vout_rel);
  wire         wr_map    = wr_addr == `OFS_OP_CTRL || wr_addr == `OFS_PWM_MODE || wr_addr == `OFS_VOUT_CMD ||
                           wr_addr == `OFS_SCALE_LOOP || wr_addr == `OFS_RAMP_STEP || wr_addr == `OFS_TON_MAX;
  wire         wr_scale  = do_wr && wr_addr == `OFS_SCALE_LOOP && wstrb_ok;
  assign wstrb_ok = wr_strb[0] && wr_strb[1];
  logic [31:0] rd_data;
  logic        rd_map;
  always_comb begin
    rd_map  = 1'b1;
    rd_data = 32'h0;
    unique case (araddr)
      `OFS_OP_CTRL:    rd_data = {29'h0, op_ctrl};
      `OFS_PWM_MODE:   rd_data = {24'h0, pwm_mode_config};
      `OFS_VOUT_CMD:   rd_data = {16'h0, vout_cmd};
      `OFS_SCALE_LOOP: rd_data = {16'h0, scale_loop};
      `OFS_RAMP_STEP:  rd_data = {16'h0, ramp_step};
      `OFS_TON_MAX:    rd_data = {16'h0, ton_max};
      `OFS_BUSY_STAT:  rd_data = {25'h0, busy, busy, 5'h0};
      `OFS_VOUT_MAX:   rd_data = {16'h0, vout_max};
      // Warning bits 7:6 stay zero: warning limits are disabled
      `OFS_STATUS:     rd_data = {16'h0, ramp[15:8], 2'b00, servo_active, ov_fault, uv_fault,
                                  stage_en, 2'(state)};
      `OFS_EA_REF:     rd_data = {16'h0, ea_ref};
      default:         rd_map  = 1'b0;
    endcase
  end

  // Write side: address and data are latched independently, committed together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      wr_addr <= 8'h0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_hold <= 1'b1;
        awready <= 1'b0;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold  <= 1'b1;
        wready  <= 1'b0;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (do_wr) begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
        bvalid  <= 1'b1;
        bresp   <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_ctrl         <= 3'h0;
      pwm_mode_config <= 8'h00;
      vout_cmd        <= `RST_VOUT_CMD;
      scale_loop      <= 16'h0000;
      ramp_step       <= `RST_RAMP_STEP;
      ton_max         <= 16'h0000;
    end else if (ce && do_wr) begin
      if (wr_strb[0] && wr_addr == `OFS_OP_CTRL) op_ctrl <= wr_data[2:0];
      if (wr_strb[0] && wr_addr == `OFS_PWM_MODE) pwm_mode_config <= wr_data[7:0];
      if (wstrb_ok && wr_addr == `OFS_VOUT_CMD) vout_cmd <= wr_data[15:0];
      if (wr_scale) scale_loop <= wr_data[15:0];
      if (wstrb_ok && wr_addr == `OFS_RAMP_STEP) ramp_step <= wr_data[15:0];
      if (wstrb_ok && wr_addr == `OFS_TON_MAX) ton_max <= wr_data[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_data;
        rresp   <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Recalculation only advances with the rail off, so a running rail stretches busy
  always_ff @(posedge aclk) begin
    if (!aresetn) busy_cnt <= 32'h0;
    else if (ce) begin
      if (wr_scale) busy_cnt <= 32'(RECAL_CYCLES);
      else if (busy && state == RAIL_OFF) busy_cnt <= busy_cnt - 32'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) tick_cnt <= 32'h0;
    else if (ce) tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) run_release <= 1'b0;
    else if (ce) run_release <= init_done && vin_above_on;
  end

  // Rail sequencing; faults bypass the soft-off ramp
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= RAIL_OFF;
      stage_en  <= 1'b0;
      ramp      <= 16'h0000;
      ton_ticks <= 16'h0000;
    end else if (ce) begin
      if (tick && state != RAIL_OFF && ton_ticks != 16'hffff) ton_ticks <= ton_ticks + 16'h1;
      unique case (state)
        RAIL_OFF: if (want_on && !fault_now) begin
          state     <= RAIL_RISE;
          stage_en  <= 1'b1;
          ton_ticks <= 16'h0000;
          ramp      <= 16'h0000;
        end
        RAIL_RISE: begin
          if (skip_ramp) ramp <= setpoint;
          else if (tick) ramp <= step_toward(ramp, setpoint, ramp_step);
          if (ramp == setpoint) state <= RAIL_ON;
        end
        RAIL_ON: if (tick || skip_ramp) ramp <= skip_ramp ? setpoint : step_toward(ramp, setpoint, ramp_step);
        RAIL_FALL: begin
          if (skip_ramp) ramp <= 16'h0000;
          else if (tick) ramp <= step_toward(ramp, 16'h0000, ramp_step);
          if (ramp == 16'h0000) begin
            state    <= RAIL_OFF;
            stage_en <= 1'b0;
          end
        end
      endcase
      if ((state == RAIL_RISE || state == RAIL_ON) && !want_on) state <= RAIL_FALL;
      if (fault_now && state != RAIL_OFF) begin
        state    <= RAIL_OFF;
        stage_en <= 1'b0;
        ramp     <= 16'h0000;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uv_fault <= 1'b0;
      ov_fault <= 1'b0;
    end else if (ce) begin
      if (state == RAIL_OFF && !op_ctrl[`BIT_OP_ON]) begin
        uv_fault <= 1'b0;
        ov_fault <= 1'b0;
      end
      if (adc_valid && state == RAIL_ON && adc_code < uv_limit) uv_fault <= 1'b1;
      if (adc_valid && state != RAIL_OFF && adc_code > ov_limit) ov_fault <= 1'b1;
    end
  end

  // One reference code is one 297.5 uV servo step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      servo_active <= 1'b0;
      ea_ref       <= 16'h0000;
    end else if (ce) begin
      servo_active <= next_servo;
      if (servo_active && next_servo) begin
        if (adc_valid && adc_code < setpoint) ea_ref <= ea_ref + 16'h1;
        else if (adc_valid && adc_code > setpoint) ea_ref <= ea_ref - 16'h1;
      end else begin
        ea_ref <= ramp;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_scale_write;
    ce && wr_scale;
  endsequence
  sequence s_busy_shown;
    busy && (rd_data[`BIT_BUSY_HI] || araddr != `OFS_BUSY_STAT);
  endsequence

  a_busy_after_scale: assert property (s_scale_write |=> s_busy_shown)
    else $error("busy not shown after scale write");
  a_hold_vout_busy: assert property (busy && aw_hold && w_hold && vout_rel |-> !do_wr)
    else $error("voltage write taken while busy");
  a_servo_step_one: assert property (ce && $past(ce) && servo_active && $past(servo_active) && next_servo
    |-> (ea_ref - $past(ea_ref) == 16'h1) || ($past(ea_ref) - ea_ref == 16'h1) || ea_ref == $past(ea_ref))
    else $error("servo moved more than one step");
  a_servo_gate: assert property (servo_active |-> $past(pwm_mode_config[`BIT_SERVO_EN]) && !$past(uv_fault))
    else $error("servo active without its conditions");
  a_servo_ton_wait: assert property (servo_active && $past(ton_max) != 16'h0000
    |-> $past(ton_ticks) >= $past(ton_max))
    else $error("servo engaged before turn-on limit");
  a_ramp_tick_rate: assert property (ce && state == RAIL_RISE && !skip_ramp && !tick
    ##1 state == RAIL_RISE |-> $stable(ramp))
    else $error("ramp moved between ticks");
  a_fault_stage_off: assert property (ce && rail_fault && state != RAIL_OFF |=> !stage_en && state == RAIL_OFF)
    else $error("stage not off after fault");
  a_run_low_fall: assert property (ce && state == RAIL_ON && !run_pin && !fault_now |=> state == RAIL_FALL)
    else $error("no soft-off after run low");
  a_rise_from_zero: assert property (ce && state == RAIL_OFF ##1 state == RAIL_RISE |-> ramp == 16'h0000)
    else $error("soft-start not from zero");
  a_start_needs_run: assert property (ce && state == RAIL_OFF ##1 state == RAIL_RISE |-> $past(run_release))
    else $error("soft-start before run release");
endmodule

// >>> tb/stage_adc_model.sv
// Power stage and output ADC model: periodic conversions while the stage runs
module stage_adc_model (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  stage_en,
  input  wire vout_ramp_pkg::vcode_t level,
  output logic                       adc_valid,
  output vout_ramp_pkg::vcode_t      adc_code
);
  import vout_ramp_pkg::*;
  int cnt;
  initial begin
    adc_valid = 1'b0;
    adc_code = 16'h0000;
    cnt = 0;
  end
  // Fixed 16-cycle conversion pace lets the bench count one servo step per window
  always @(posedge aclk) begin
    if (!aresetn || !stage_en) begin
      cnt <= 0;
      adc_valid <= 1'b0;
      adc_code <= ~adc_code;
    end else begin
      cnt <= (cnt == 15) ? 0 : cnt + 1;
      adc_valid <= (cnt == 15);
      adc_code <= level;
    end
  end
endmodule

// >>> tb/tb_output_voltage_ramp_servo_control.sv
// Self-checking bench for the output voltage ramp and servo control block
`include "vout_ramp_consts.svh"
module tb_output_voltage_ramp_servo_control;
  timeunit 1ns;
  timeprecision 1ps;
  import vout_ramp_pkg::*;
  localparam int TICK = 8;
  localparam int RECAL = 50;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0, lf = 8'h54;
  logic [31:0] wdata = 0, rdata, d, d0;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, arready, bvalid, rvalid, run_release, stage_en, uv_fault, ov_fault;
  logic        servo_active, adc_valid, prev_stage = 0, prev_servo = 0;
  logic        run_pin = 0, init_done = 0, vin_above_on = 0, oc_fault = 0, rail_fault = 0;
  vcode_t      adc_code, ea_ref, prev_ref = 0, level = 0, p;
  int          n_mismatch = 0, tests_run = 0, cyc = 0, since = 1000, rstep = 16, t0, s;
  int          nom = 'h540;

  always #2 aclk = ~aclk;

  vout_ramp_ctrl #(.RECAL_CYCLES(RECAL), .TICK_CYCLES(TICK), .BASE_VARIANT(1'b0)) dut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .run_pin(run_pin), .init_done(init_done), .vin_above_on(vin_above_on),
    .adc_valid(adc_valid), .adc_code(adc_code), .oc_fault(oc_fault), .rail_fault(rail_fault),
    .run_release(run_release), .stage_en(stage_en), .ea_ref(ea_ref), .uv_fault(uv_fault), .ov_fault(ov_fault),
    .servo_active(servo_active));

  stage_adc_model partner (.aclk(aclk), .aresetn(aresetn), .stage_en(stage_en), .level(level),
    .adc_valid(adc_valid), .adc_code(adc_code));

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_sim;
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    rs = 2'h3;
    for (n = 0; n < 5000; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        break;
      end
    end
    chk("write answered", 1, n < 5000);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 5000; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        v = rdata;
        rs = rresp;
        break;
      end
    end
    chk("read answered", 1, n < 5000);
  endtask

  task automatic wait_ref(input vcode_t v, input int lim);
    for (int n = 0; n < lim && ea_ref !== v; n++) @(posedge aclk);
    chk("ea_ref", v, ea_ref);
  endtask

  // Ramp pacing and soft-off ending watched on every cycle
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    prev_ref <= ea_ref;
    prev_stage <= stage_en;
    prev_servo <= servo_active;
    // Servo moves and the hand-back to the ramp are not ramp steps
    since <= (ea_ref !== prev_ref && !prev_servo && !servo_active) ? 1 : since + 1;
    if (aresetn && prev_stage && stage_en && !prev_servo && !servo_active &&
        ea_ref !== prev_ref && rstep != 'hffff) begin
      chk("ramp spacing", 1, since >= TICK);
      chk("ramp step", 1, (ea_ref > prev_ref ? ea_ref - prev_ref : prev_ref - ea_ref) <= rstep);
    end
    if (aresetn && prev_stage && !stage_en && !rail_fault && !uv_fault && !ov_fault)
      chk("soft off end", 0, ea_ref);
  end

  initial begin
    #200000;
    n_mismatch++;
    end_sim;
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    vin_above_on <= 1'b1;
    run_pin <= 1'b1;
    level <= vcode_t'(nom);
    @(posedge aclk);
    rd(`OFS_PWM_MODE, d, r); chk("pwm_mode", 0, d);
    rd(`OFS_VOUT_CMD, d, r); chk("vout_cmd", `RST_VOUT_CMD, d);
    rd(`OFS_RAMP_STEP, d, r); chk("ramp_step", `RST_RAMP_STEP, d);
    rd(`OFS_TON_MAX, d, r); chk("ton_max", 0, d);
    rd(8'h3c, d, r); chk("unmapped rresp", `RESP_SLVERR, r);
    wr(8'h3c, 1, r); chk("unmapped bresp", `RESP_SLVERR, r);
    rd(`OFS_VOUT_MAX, d0, r);
    wr(`OFS_VOUT_MAX, ~d0, r);
    rd(`OFS_VOUT_MAX, d, r); chk("vout_max read only", d0, d);
    // Rail asked on before init is done must stay idle
    wr(`OFS_OP_CTRL, 1, r);
    repeat (20) @(posedge aclk);
    chk("run_release early", 0, run_release);
    chk("stage early", 0, stage_en);
    init_done <= 1'b1;
    wait_ref(nom, 2000);
    wr(`OFS_OP_CTRL, 1 | (`MARGIN_HIGH << 1), r);
    wait_ref(nom + nom / 20, 2000);
    wr(`OFS_OP_CTRL, 1 | (`MARGIN_LOW << 1), r);
    wait_ref(nom - nom / 20, 2000);
    wr(`OFS_OP_CTRL, 0, r);
    for (int n = 0; n < 3000 && stage_en; n++) @(posedge aclk);
    chk("stage off", 0, stage_en);
    // Fastest rate skips the ramp; a rail fault drops the stage at once
    rstep = 'hffff;
    wr(`OFS_RAMP_STEP, 'hffff, r);
    wr(`OFS_OP_CTRL, 1, r);
    wait_ref(nom, TICK + 4);
    rail_fault <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("fault stage", 0, stage_en);
    wr(`OFS_OP_CTRL, 0, r);
    rail_fault <= 1'b0;
    // Scale factor written with the rail off; voltage write held off meanwhile
    wr(`OFS_SCALE_LOOP, 2, r);
    t0 = cyc;
    rd(`OFS_BUSY_STAT, d, r); chk("busy bits", 2'b11, d[6:5]);
    wr(`OFS_VOUT_CMD, 'h0400, r); chk("holdoff", 1, cyc - t0 >= RECAL);
    rd(`OFS_BUSY_STAT, d, r); chk("busy clear", 0, d[6:5]);
    rd(`OFS_VOUT_MAX, d, r); chk("vout_max", 2 * `MAX_PER_SCALE, d);
    // Servo in scale mode, random offset from the command in both directions
    rstep = 16;
    wr(`OFS_RAMP_STEP, 16, r);
    wr(`OFS_PWM_MODE, 'h40, r);
    wr(`OFS_TON_MAX, 0, r);
    lf = lfsr(lf);
    level <= 16'h0400 - {12'h0, lf[3:0]} - 16'h0001;
    wr(`OFS_OP_CTRL, 1, r);
    for (int n = 0; n < 5000 && !servo_active; n++) @(posedge aclk);
    chk("servo on", 1, servo_active);
    for (int dir = 0; dir < 2; dir++) begin
      s = dir ? -1 : 1;
      if (dir) level <= 16'h0400 + {12'h0, lf[7:4]} + 16'h0001;
      repeat (32) @(posedge aclk);
      p = ea_ref;
      for (int i = 0; i < 4; i++) begin
        repeat (16) @(posedge aclk);
        chk("servo step", vcode_t'(p + s), ea_ref);
        p = ea_ref;
      end
    end
    oc_fault <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("servo off on oc", 0, servo_active);
    oc_fault <= 1'b0;
    // Output beyond the fault limits drops the stage at once; faults stay until off
    level <= 16'h0400 + 16'h0400 / 16'h000a + 16'h0001;
    for (int n = 0; n < 100 && stage_en; n++) @(posedge aclk);
    chk("ov_fault", 1, ov_fault);
    chk("ov stage off", 0, stage_en);
    wr(`OFS_OP_CTRL, 0, r);
    repeat (2) @(posedge aclk);
    chk("ov cleared", 0, ov_fault);
    level <= 16'h0400 - 16'h0400 / 16'h000a - 16'h0001;
    wr(`OFS_OP_CTRL, 1, r);
    for (int n = 0; n < 3000 && !uv_fault; n++) @(posedge aclk);
    chk("uv_fault", 1, uv_fault);
    wr(`OFS_OP_CTRL, 0, r);
    for (int n = 0; n < 3000 && stage_en; n++) @(posedge aclk);
    chk("final off", 0, stage_en);
    end_sim;
  end
endmodule
